// ==== rtl/xcvr_sched.sv ====
/*
  Transceiver mode control, remote wakeup detection and the
  immediate or timestamp-spaced transmit scheduler, as an APB slave.
  Assumes a same-clock CAN controller taking tx_valid/tx_frame and
  answering tx_done; bus_rx_pin is asynchronous and synchronised here.
*/
`timescale 1ns/1ns
module xcvr_sched #(
  parameter int QDEPTH = 4
) (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic [31:0]                 prdata,
  // transceiver side
  input  wire logic                   bus_rx_pin,
  output xcvr_sched_pkg::xcvr_ctl_t   xcvr_ctl,
  // can controller side
  output logic                        ctrl_rx_en,
  output logic                        tx_valid,
  output xcvr_sched_pkg::frame_t      tx_frame,
  input  wire logic                   tx_done
);
  import xcvr_sched_pkg::*;

  typedef struct packed {
    logic        rx_s1;
    logic        rx_s2;
    pm_t         pm;
    logic [1:0]  mode;
    logic        started;
    logic        txm;
    logic        recov;
    logic [2:0]  xtype;
    logic        err;
    logic        rwake;
    logic [11:0] idle;
    logic [7:0]  tick;
    logic [16:0] elapsed;
    logic [15:0] prev_ts;
    logic        have_prev;
    logic        tx_valid;
    frame_t      tx_frame;
    logic        rx_en;
    xcvr_ctl_t   ctl;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } st_t;
  st_t st_ff, nxt_st;

  logic   acc, wr, wr_mode, q_in_ready, q_out_valid, q_pop;
  frame_t q_head;
  logic [15:0] gap;

  initial begin
    if (IDLE_CYC >= 4096 || TICK_CYC >= 256)
      $error("idle or tick counter too narrow");
  end

  // one access cycle before pready, so pready comes from a flop
  assign acc     = psel && penable && !st_ff.pready;
  assign wr      = acc && pwrite;
  assign wr_mode = wr && paddr == OFS_MODE;
  assign gap     = q_head.ts - st_ff.prev_ts;

  tx_queue #(.W($bits(frame_t)), .DEPTH(QDEPTH)) u_q (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (wr && paddr == OFS_TXQ),
    .in_data   (pwdata),
    .in_ready  (q_in_ready),
    .out_valid (q_out_valid),
    .out_data  (q_head),
    .out_ready (q_pop)
  );

  // a finished frame leaves the queue; a withdrawn one stays at the head
  assign q_pop = st_ff.tx_valid && tx_done;

  always_comb begin
    logic comm;
    logic due;
    nxt_st         = st_ff;
    nxt_st.rx_s1   = bus_rx_pin;
    nxt_st.rx_s2   = st_ff.rx_s1;
    nxt_st.pready  = acc;
    nxt_st.pslverr = 1'b0;
    // timestamp tick and elapsed time since the last frame left
    if (st_ff.tick == 8'(TICK_CYC - 1)) begin
      nxt_st.tick = 8'h00;
      if (!(&st_ff.elapsed))
        nxt_st.elapsed = st_ff.elapsed + 17'h00001;
    end else begin
      nxt_st.tick = st_ff.tick + 8'h01;
    end
    // remote wakeup watch
    case (st_ff.pm)
      PM_SLEEP: begin
        if (!st_ff.rx_s2) begin
          nxt_st.pm   = PM_WAKING;
          nxt_st.idle = 12'h000;
        end
      end
      PM_WAKING: begin
        if (!st_ff.rx_s2)
          nxt_st.idle = 12'h000;
        else if (st_ff.idle == 12'(IDLE_CYC - 1)) begin
          nxt_st.pm    = PM_NORMAL;
          nxt_st.mode  = XM_NORMAL;
          nxt_st.rwake = 1'b1;
        end else
          nxt_st.idle = st_ff.idle + 12'h001;
      end
      default: nxt_st.idle = 12'h000;
    endcase
    // register writes
    if (wr) begin
      if (paddr == OFS_CTRL) begin
        if (!st_ff.started) begin
          nxt_st.txm   = pwdata[CTRL_TXM];
          nxt_st.recov = pwdata[CTRL_RECOV];
          nxt_st.xtype = pwdata[CTRL_TYPE +: 3];
        end
        if (st_ff.started && !pwdata[CTRL_START])
          nxt_st.rwake = 1'b0;
        nxt_st.started = pwdata[CTRL_START];
      end else if (paddr == OFS_MODE) begin
        nxt_st.rwake = 1'b0;
        case (pwdata[1:0])
          XM_NORMAL: begin
            nxt_st.pm   = PM_NORMAL;
            nxt_st.mode = XM_NORMAL;
          end
          XM_SLEEP: begin
            if (st_ff.started) begin
              nxt_st.pm   = PM_SLEEP;
              nxt_st.mode = XM_SLEEP;
            end else
              nxt_st.err = 1'b1;
          end
          default: begin
            // single-wire only; high-speed never straight out of sleep
            if (st_ff.xtype != XT_SW ||
                (pwdata[1:0] == XM_SWHS && st_ff.pm != PM_NORMAL))
              nxt_st.err = 1'b1;
            else begin
              nxt_st.pm   = PM_NORMAL;
              nxt_st.mode = pwdata[1:0];
            end
          end
        endcase
      end else if (paddr == OFS_STAT) begin
        if (pwdata[STAT_ERR])
          nxt_st.err = 1'b0;
        if (pwdata[STAT_RWAKE] && nxt_st.rwake == st_ff.rwake)
          nxt_st.rwake = 1'b0;
      end else if (paddr == OFS_TXQ) begin
        nxt_st.pslverr = !q_in_ready; // full queue refuses the frame
      end else
        nxt_st.pslverr = 1'b1;
    end else if (acc && paddr != OFS_CTRL && paddr != OFS_MODE &&
                 paddr != OFS_STAT && paddr != OFS_TXQ)
      nxt_st.pslverr = 1'b1;
    // the wake flag set by hardware outlives a status or stop clear in the same cycle, not a mode write
    if (st_ff.pm == PM_WAKING && nxt_st.pm == PM_NORMAL && !wr_mode)
      nxt_st.rwake = 1'b1;
    // read data
    nxt_st.prdata = 32'h0000_0000;
    if (acc && !pwrite) begin
      if (paddr == OFS_CTRL)
        nxt_st.prdata = {25'h0, st_ff.xtype, 1'b0, st_ff.recov, st_ff.txm, st_ff.started};
      else if (paddr == OFS_MODE)
        nxt_st.prdata = {30'h0, st_ff.mode};
      else if (paddr == OFS_STAT)
        nxt_st.prdata = {28'h0, !q_in_ready, st_ff.pm != PM_NORMAL,
                         st_ff.rwake, st_ff.err};
    end
    // scheduler: only while started, awake and on a connected transceiver
    comm = nxt_st.started && nxt_st.pm == PM_NORMAL && st_ff.xtype != XT_DISC;
    due  = !st_ff.txm || !st_ff.have_prev || q_head.ts < st_ff.prev_ts ||
           st_ff.elapsed >= {1'b0, gap};
    if (st_ff.tx_valid && tx_done) begin
      nxt_st.tx_valid  = 1'b0;
      nxt_st.prev_ts   = q_head.ts;
      nxt_st.have_prev = 1'b1;
      if (st_ff.txm && st_ff.recov && st_ff.have_prev && q_head.ts >= st_ff.prev_ts)
        nxt_st.elapsed = st_ff.elapsed - {1'b0, gap};
      else begin
        // restart the tick too, so a fresh gap is not cut short by tick phase
        nxt_st.elapsed = 17'h00000;
        nxt_st.tick    = 8'h00;
      end
    end else if (st_ff.tx_valid && !comm) begin
      nxt_st.tx_valid = 1'b0;
    end else if (!st_ff.tx_valid && q_out_valid && comm && due) begin
      nxt_st.tx_valid = 1'b1;
      nxt_st.tx_frame = q_head;
    end
    if (!nxt_st.started)
      nxt_st.have_prev = 1'b0;
    nxt_st.rx_en              = comm;
    nxt_st.ctl.sleep          = nxt_st.pm != PM_NORMAL;
    nxt_st.ctl.wake_level     = nxt_st.mode == XM_SWWAKE;
    nxt_st.ctl.waveshape_off  = nxt_st.mode == XM_SWHS;
    nxt_st.ctl.disconnect     = nxt_st.xtype == XT_DISC;
    // type output moves only while stopped, so the bus never sees it
    nxt_st.ctl.xtype          = nxt_st.xtype;
  end

  // state register; reset gives normal mode, immediate transmit, stopped
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff       <= '0;
      st_ff.rx_s1 <= 1'b1;
      st_ff.rx_s2 <= 1'b1;
      st_ff.pm    <= PM_NORMAL;
    end else
      st_ff <= nxt_st;
  end

  assign pready     = st_ff.pready;
  assign pslverr    = st_ff.pslverr;
  assign prdata     = st_ff.prdata;
  assign xcvr_ctl   = st_ff.ctl;
  assign ctrl_rx_en = st_ff.rx_en;
  assign tx_valid   = st_ff.tx_valid;
  assign tx_frame   = st_ff.tx_frame;

  property p_sleep_refused;
    @(posedge mclk) disable iff (sys_rst)
      wr_mode && pwdata[1:0] == XM_SLEEP && !st_ff.started |=> st_ff.err;
  endproperty
  a_sleep_refused: assert property (p_sleep_refused) else $error("sleep taken while stopped");

  property p_sleep_taken;
    @(posedge mclk) disable iff (sys_rst)
      wr_mode && pwdata[1:0] == XM_SLEEP && st_ff.started
      |=> st_ff.pm == PM_SLEEP && xcvr_ctl.sleep && st_ff.mode == XM_SLEEP;
  endproperty
  a_sleep_taken: assert property (p_sleep_taken) else $error("sleep not entered");

  property p_quiet;
    @(posedge mclk) disable iff (sys_rst)
      st_ff.pm != PM_NORMAL |-> !tx_valid && !ctrl_rx_en;
  endproperty
  a_quiet: assert property (p_quiet) else $error("activity while asleep");

  property p_local_wake;
    @(posedge mclk) disable iff (sys_rst)
      wr_mode && pwdata[1:0] == XM_NORMAL && st_ff.pm != PM_NORMAL
      |=> st_ff.pm == PM_NORMAL && !st_ff.rwake;
  endproperty
  a_local_wake: assert property (p_local_wake) else $error("local wakeup missed");

  property p_remote_wake;
    @(posedge mclk) disable iff (sys_rst)
      st_ff.pm == PM_WAKING && !wr_mode ##1 st_ff.pm == PM_NORMAL
      |-> st_ff.rwake && st_ff.mode == XM_NORMAL ##1 ctrl_rx_en || !st_ff.started;
  endproperty
  a_remote_wake: assert property (p_remote_wake) else $error("remote wakeup not shown");

  property p_no_hs_from_sleep;
    @(posedge mclk) disable iff (sys_rst)
      wr_mode && pwdata[1:0] == XM_SWHS && st_ff.pm != PM_NORMAL
      |=> $stable(st_ff.mode) && st_ff.err;
  endproperty
  a_no_hs_from_sleep: assert property (p_no_hs_from_sleep) else $error("hs entered from sleep");

  property p_sw_only;
    @(posedge mclk) disable iff (sys_rst)
      wr_mode && pwdata[1] && st_ff.xtype != XT_SW |=> $stable(st_ff.mode);
  endproperty
  a_sw_only: assert property (p_sw_only) else $error("single-wire mode on other type");

  property p_type_frozen;
    @(posedge mclk) disable iff (sys_rst)
      st_ff.started && $past(st_ff.started) |-> $stable(xcvr_ctl.xtype) && $stable(st_ff.txm);
  endproperty
  a_type_frozen: assert property (p_type_frozen) else $error("config changed while running");

  property p_immediate;
    @(posedge mclk) disable iff (sys_rst)
      !st_ff.txm && !tx_valid && q_out_valid && ctrl_rx_en && st_ff.started &&
      !wr_mode && st_ff.pm == PM_NORMAL |=> tx_valid && tx_frame == $past(q_head);
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate frame delayed");
endmodule // xcvr_sched

// ==== rtl/xcvr_sched_pkg.sv ====
/*
  Constants, encodings and carrier types for the transceiver mode
  controller and transmit scheduler.
  Assumes a 125 MHz mclk and a 32-bit APB register port.
*/
// What this block does
// - mode value 1 puts transceiver and controller to sleep; all standby kinds equal
// - sleep request taken only while started, otherwise refused with error flag
// - asleep nothing sent or received; pending frames held until wakeup
// - writing mode 0, or mode 2 on a single-wire port, while asleep performs a local wakeup; mode 3 is refused
// - the waking frame is neither stored nor acknowledged
// - at the end of the waking frame return to normal and communicate
// - after wakeup queued frames resume in order, none dropped
// - remote wakeup shows as mode normal plus a readable wake flag
// - mode 2 on single-wire port drives wakeup level, frames as normal
// - mode 3 on single-wire port turns waveshaping off, otherwise normal
// - high-speed mode never entered directly from sleep
// - transceiver type changes only while communication is stopped
// - type codes 0 hs, 1 ls fault tolerant, 2 single wire, 3 external, 4 disconnect
// - type switch never disturbs the bus
// - transmit mode 0 sends queued frames at once, timestamps ignored
// - transmit mode 1 spaces frames by their timestamp difference
// - a timestamp below its predecessor resets spacing and sends at once
// - transmit mode only taken while the interface is stopped
// - mode value 0 is normal and default; from sleep it wakes locally
// - with recovery on a late frame shortens the next gap, else gaps never shrink
package xcvr_sched_pkg;
  localparam logic [7:0]  OFS_CTRL = 8'h00;
  localparam logic [7:0]  OFS_MODE = 8'h04;
  localparam logic [7:0]  OFS_STAT = 8'h08;
  localparam logic [7:0]  OFS_TXQ  = 8'h0c;
  // control word fields
  localparam int          CTRL_START = 0;
  localparam int          CTRL_TXM   = 1;
  localparam int          CTRL_RECOV = 2;
  localparam int          CTRL_TYPE  = 4;
  // status word fields; error and wake flag write one to clear, sleep and full read only
  localparam int          STAT_ERR   = 0;
  localparam int          STAT_RWAKE = 1;
  localparam int          STAT_SLEEP = 2;
  localparam int          STAT_FULL  = 3;
  localparam logic [1:0]  XM_NORMAL  = 2'h0;
  localparam logic [1:0]  XM_SLEEP   = 2'h1;
  localparam logic [1:0]  XM_SWWAKE  = 2'h2;
  localparam logic [1:0]  XM_SWHS    = 2'h3;
  localparam logic [2:0]  XT_HS      = 3'h0;
  localparam logic [2:0]  XT_LS      = 3'h1;
  localparam logic [2:0]  XT_SW      = 3'h2;
  localparam logic [2:0]  XT_EXT     = 3'h3;
  localparam logic [2:0]  XT_DISC    = 3'h4;
  // timing: timestamp tick and bus bit time
  localparam int          CLK_NS     = 8;
  localparam int          TICK_NS    = 1000;
  localparam int          TICK_CYC   = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int          BIT_NS     = 2000;
  localparam int          IDLE_BITS  = 11;
  localparam int          IDLE_CYC   = (IDLE_BITS * BIT_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_SLEEP  = 2'b01,
    PM_WAKING = 2'b10
  } pm_t;
  typedef struct packed {
    logic [15:0] ts;
    logic [15:0] tag;
  } frame_t;
  typedef struct packed {
    logic       sleep;
    logic       wake_level;
    logic       waveshape_off;
    logic       disconnect;
    logic [2:0] xtype;
  } xcvr_ctl_t;
endpackage

// ==== rtl/tx_queue.sv ====
/*
  Write queue of frames waiting for transmission, flip-flop storage.
  Assumes single clock; source and sink both use valid/ready.
*/
`timescale 1ns/1ns
module tx_queue #(
  parameter int W     = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } q_t;
  q_t st_ff, nxt_st;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("tx_queue depth must be a power of two, at least 2");
  end

  assign in_ready  = st_ff.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_ff.cnt != '0;
  assign out_data  = st_ff.mem[st_ff.rp];

  // order is kept strictly: the head leaves only on out_ready
  always_comb begin
    logic push;
    logic pop;
    push   = in_valid && in_ready;
    pop    = out_valid && out_ready;
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp            = st_ff.wp + 1'b1;
    end
    if (pop)
      nxt_st.rp = st_ff.rp + 1'b1;
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
endmodule // tx_queue

// ==== dv/can_far_node.sv ====
/*
  far side model: the can controller answering offered frames and a
  remote node that can send a wakeup frame on the bus.
  assumes the scheduler's mclk and an active high async reset.
*/
`timescale 1ns/1ns
module can_far_node #(
  parameter int DLY      = 3,
  parameter int WAKE_LEN = 200
) (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  // controller side
  input  wire logic                    tx_valid,
  input  wire xcvr_sched_pkg::frame_t  tx_frame,
  output logic                         tx_done,
  // bus side
  input  wire logic                    send_wake,
  output logic                         bus_rx_pin
);
  logic        tx_valid_q;
  logic        acked;
  int          cnt;
  int          wake_cnt;
  int          cyc;
  int          last_done;
  logic [15:0] tags[$];
  int          gaps[$];

  // log each offered frame and its gap from the previous done
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_valid_q <= 1'b0;
      acked      <= 1'b0;
      tx_done    <= 1'b0;
      bus_rx_pin <= 1'b1;
      cnt        <= 0;
      wake_cnt   <= 0;
      cyc        <= 0;
      last_done  <= 0;
    end else begin
      cyc        <= cyc + 1;
      tx_valid_q <= tx_valid;
      tx_done    <= 1'b0;
      if (tx_valid && !tx_valid_q) begin
        tags.push_back(tx_frame.tag);
        gaps.push_back(cyc - last_done);
      end
      // one done pulse per offer, never while the offer is down
      if (!tx_valid) begin
        cnt   <= 0;
        acked <= 1'b0;
      end else if (!acked && cnt == DLY) begin
        tx_done   <= 1'b1;
        acked     <= 1'b1;
        last_done <= cyc;
      end else if (!acked) begin
        cnt <= cnt + 1;
      end
      // wakeup frame: dominant span, then recessive idle
      if (send_wake) begin
        wake_cnt <= WAKE_LEN;
      end else if (wake_cnt != 0) begin
        wake_cnt <= wake_cnt - 1;
      end
      bus_rx_pin <= (wake_cnt == 0);
    end
  end
endmodule // can_far_node

// ==== dv/tb_top.sv ====
/*
  self-checking bench of the transceiver mode and transmit scheduler.
  assumes the package constants and the can_far_node partner model.
*/
`timescale 1ns/1ns
module tb_top;
  import xcvr_sched_pkg::*;
  logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        bus_rx_pin, ctrl_rx_en, tx_valid, tx_done, send_wake, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  xcvr_ctl_t   xcvr_ctl;
  frame_t      tx_frame;
  int          num_errors, n_compared;
  logic [2:0]  types[5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};

  xcvr_sched u_xcvr_sched (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .bus_rx_pin(bus_rx_pin), .xcvr_ctl(xcvr_ctl), .ctrl_rx_en(ctrl_rx_en),
    .tx_valid(tx_valid), .tx_frame(tx_frame), .tx_done(tx_done));
  can_far_node u_can_far_node (.mclk(mclk), .sys_rst(sys_rst), .tx_valid(tx_valid),
    .tx_frame(tx_frame), .tx_done(tx_done), .send_wake(send_wake), .bus_rx_pin(bus_rx_pin));

  always #4 mclk = ~mclk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; holds the request until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) check(32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // registered config outputs get a few edges to follow the write
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (3) @(posedge mclk);
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task wait_tags(input int k);
    int n;
    n = 0;
    while (u_can_far_node.tags.size() < k && n < 5000) begin
      @(posedge mclk);
      n++;
    end
  endtask

  task complete_run;
    $display("counts: compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog: the tests need well under 20000 cycles
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    complete_run;
  end

  initial begin
    mclk = 0; sys_rst = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; send_wake = 0; num_errors = 0; n_compared = 0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rdchk(OFS_MODE, 32'h0);
    check({25'h0, xcvr_ctl}, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, er}, 32'h1);
    $display("test reset done");
    wr(OFS_MODE, 32'h1);
    rdchk(OFS_MODE, 32'h0);
    rdchk(OFS_STAT, 32'h1);
    wr(OFS_STAT, 32'h1);
    // single wire port: wake level, frame, back to normal, then no shaping
    wr(OFS_CTRL, 32'h20);
    wr(OFS_CTRL, 32'h21);
    wr(OFS_MODE, 32'h2);
    check({31'h0, xcvr_ctl.wake_level}, 32'h1);
    wr(OFS_TXQ, 32'h1);
    wait_tags(1);
    wr(OFS_MODE, 32'h0);
    check({31'h0, xcvr_ctl.wake_level}, 32'h0);
    check({16'h0, u_can_far_node.tags[0]}, 32'h1);
    wr(OFS_MODE, 32'h3);
    check({31'h0, xcvr_ctl.waveshape_off}, 32'h1);
    wr(OFS_MODE, 32'h0);
    $display("test single wire done");
    // sleep holds frames; high speed refused; local wake resumes in order
    wr(OFS_MODE, 32'h1);
    check({31'h0, xcvr_ctl.sleep}, 32'h1);
    check({31'h0, ctrl_rx_en}, 32'h0);
    wr(OFS_TXQ, 32'h2);
    wr(OFS_TXQ, 32'h3);
    repeat (200) @(posedge mclk);
    check(u_can_far_node.tags.size(), 32'h1);
    wr(OFS_MODE, 32'h3);
    rdchk(OFS_STAT, 32'h5);
    wr(OFS_STAT, 32'h1);
    wr(OFS_MODE, 32'h0);
    check({31'h0, xcvr_ctl.sleep}, 32'h0);
    wait_tags(3);
    check({16'h0, u_can_far_node.tags[1]}, 32'h2);
    check({16'h0, u_can_far_node.tags[2]}, 32'h3);
    $display("test local wake done");
    // remote wake: waking frame ignored, then normal with the flag set
    wr(OFS_MODE, 32'h1);
    wr(OFS_TXQ, 32'h4);
    send_wake <= 1'b1;
    @(posedge mclk);
    send_wake <= 1'b0;
    repeat (100) @(posedge mclk);
    check({31'h0, ctrl_rx_en}, 32'h0);
    repeat (u_can_far_node.WAKE_LEN + IDLE_CYC + 50) @(posedge mclk);
    rdchk(OFS_MODE, 32'h0);
    rdchk(OFS_STAT, 32'h2);
    check({31'h0, ctrl_rx_en}, 32'h1);
    wait_tags(4);
    check({16'h0, u_can_far_node.tags[3]}, 32'h4);
    $display("test remote wake done");
    // every type code, disconnect before external; locked while started
    wr(OFS_CTRL, 32'h0);
    foreach (types[i]) begin
      wr(OFS_CTRL, {25'h0, types[i], 4'h0});
      check({29'h0, xcvr_ctl.xtype}, {29'h0, types[i]});
      check({31'h0, xcvr_ctl.disconnect}, {31'h0, types[i] == XT_DISC});
    end
    wr(OFS_CTRL, 32'h31);
    wr(OFS_CTRL, 32'h11);
    check({29'h0, xcvr_ctl.xtype}, {29'h0, XT_EXT});
    $display("test types done");
    // timestamp spacing: 0, 10, then a smaller stamp that goes at once
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h2);
    wr(OFS_CTRL, 32'h3);
    u_can_far_node.tags.delete();
    u_can_far_node.gaps.delete();
    wr(OFS_TXQ, {16'd0, 16'h10});
    wr(OFS_TXQ, {16'd10, 16'h11});
    wr(OFS_TXQ, {16'd5, 16'h12});
    wait_tags(3);
    check(u_can_far_node.gaps[1] >= 10 * TICK_CYC - 2 &&
          u_can_far_node.gaps[1] <= 10 * TICK_CYC + 12, 32'h1);
    check(u_can_far_node.gaps[2] <= 4, 32'h1);
    check({16'h0, u_can_far_node.tags[2]}, 32'h12);
    $display("test spacing done");
    complete_run;
  end
endmodule // tb_top
